/* rtl/blank_burst_regs.svh */
`ifndef BLANK_BURST_REGS_SVH
`define BLANK_BURST_REGS_SVH
// clock 40 MHz: period in ps
`define CLK_PERIOD_PS 25000
`define MASK_NORMAL_NS 220
`define MASK_BURST_NS 180
`define MASK_NORMAL_CYC ((`MASK_NORMAL_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MASK_BURST_CYC ((`MASK_BURST_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BLANK_MS 20
`define BLANK_CYC (`BLANK_MS * 40000)
`define DETECT_MS 1
`define DETECT_CYC (`DETECT_MS * 40000)
`define SPIKE_US 30
`define SPIKE_CYC (`SPIKE_US * 40)
`define EXT_COUNT_END 16'h0100
// count boundaries for level selection (cycles of feedback pin in 1ms)
`define LVL_BOUND_HIGH 16'h0008
`define LVL_BOUND_MID 16'h0020
`define LVL_BOUND_LOW 16'h0080
`endif

/* rtl/blank_burst_pkg.sv */
package blank_burst_pkg;
	typedef enum logic [1:0] {
		LVL_HIGH = 2'h0,
		LVL_MID = 2'h1,
		LVL_LOW = 2'h2,
		LVL_NEVER = 2'h3
	} burst_level_t;
	typedef enum logic [3:0] {
		EXT_IDLE = 4'h1,
		EXT_CHARGE = 4'h2,
		EXT_DISCHARGE = 4'h4,
		EXT_DONE = 4'h8
	} ext_state_t;
	typedef enum logic [3:0] {
		DET_WAIT = 4'h1,
		DET_CHARGE = 4'h2,
		DET_DISCHARGE = 4'h4,
		DET_DONE = 4'h8
	} det_state_t;
endpackage : blank_burst_pkg

/* rtl/sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk, // clock
	input wire logic arst_n, // async reset
	input wire logic [W-1:0] d, // async input
	output logic [W-1:0] q // synchronised
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;
	always_comb begin
		meta_d = d;
		sync_d = meta_q;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= meta_d;
			q <= sync_d;
		end
	end
endmodule : sync2
`default_nettype wire

/* rtl/blank_burst_ctrl.sv */
// Function
// - mask sense 220ns normal, 180ns burst
// - 20ms persistence before burst or restart
// - overload window extendable by external capacitor
// - extension blocks fault gate until done
// - window expiry starts counter, closes charge
// - upper threshold: count, swap to discharge
// - lower threshold: swap back to charge
// - 256 cycles then completion high
// - fault and completion: 30us filter, restart
// - four entry levels incl never
// - paired current limits, always for never
// - detect first 1ms after lockout release
// - no re-detection on auto restart
// - postpone detection while protection active
// - 4.5V: set detect, discharge, count
// - 0.5V: reset detect, resume charging
// - counting stops at 1ms end
// - latch level after detection ends
// - burst needs 20ms continuous low feedback
`include "blank_burst_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module blank_burst_ctrl
	import blank_burst_pkg::*;
(
	input wire logic ref_clk, // 40 MHz clock
	input wire logic arst_n, // async reset, active low
	input wire logic gate_on, // switch turn-on pulse, same domain
	input wire logic burst_active, // burst operation in progress, same domain
	input wire logic supply_lockout_ok, // lockout released above 17V
	input wire logic restart_cycle, // start-up caused by auto restart
	input wire logic protect_active, // protection such as input overvoltage
	input wire logic fb_below_entry, // feedback below selected entry threshold
	input wire logic fb_overload, // feedback above overload threshold
	input wire logic ext_enable, // extendable blanking mode in use
	input wire logic upper_threshold_comparator, // extension pin at 4.5V
	input wire logic lower_threshold_comparator, // extension pin at 0.9V
	input wire logic fb_upper_cmp, // feedback pin at 4.5V
	input wire logic fb_lower_cmp, // feedback pin at 0.5V
	output logic turn_on_spike_mask, // comparators ignored while high
	output logic charge_switch, // extension pin charge switch
	output logic discharge_switch, // extension pin discharge switch
	output logic ext_done, // extension counter completion
	output logic auto_restart, // enter automatic restart
	output logic burst_enter, // enter burst operation
	output logic detect_flipflop, // feedback detect state
	output logic feedback_discharge_switch, // feedback pin discharge switch
	output logic level_valid, // level detection finished
	output burst_level_t burst_level, // selected entry level
	output logic burst_limit_always // current limit applies always
);
	logic [7:0] async_d;
	logic [7:0] async_q;
	logic lock_s, rst_s, prot_s, fbl_s, ovl_s, up_s, lo_s, fbu_s;
	assign async_d = {supply_lockout_ok, restart_cycle, protect_active, fb_below_entry,
		fb_overload, upper_threshold_comparator, lower_threshold_comparator, fb_upper_cmp};
	assign {lock_s, rst_s, prot_s, fbl_s, ovl_s, up_s, lo_s, fbu_s} = async_q;
	logic fbd_s;
	sync2 #(.W(8)) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d(async_d),
		.q(async_q)
	);
	sync2 #(.W(1)) u_sync_fb (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d(fb_lower_cmp),
		.q(fbd_s)
	);

	// leading-edge mask
	logic [3:0] mask_q, mask_d;
	always_comb begin
		mask_d = mask_q;
		if (gate_on)
			mask_d = burst_active ? 4'(`MASK_BURST_CYC) : 4'(`MASK_NORMAL_CYC);
		else if (mask_q != 4'h0)
			mask_d = mask_q - 4'h1;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			mask_q <= 4'h0;
		else
			mask_q <= mask_d;
	end
	assign turn_on_spike_mask = (mask_q != 4'h0);

	// 20ms windows: burst and fault
	logic [19:0] bcnt_q, bcnt_d, fcnt_q, fcnt_d;
	logic fault_win, burst_win;
	assign burst_win = (bcnt_q == 20'(`BLANK_CYC));
	assign fault_win = (fcnt_q == 20'(`BLANK_CYC));
	always_comb begin
		bcnt_d = 20'h00000;
		if (fbl_s && level_valid && burst_level != LVL_NEVER && !burst_active)
			bcnt_d = burst_win ? bcnt_q : bcnt_q + 20'h00001;
		fcnt_d = 20'h00000;
		if (ovl_s)
			fcnt_d = fault_win ? fcnt_q : fcnt_q + 20'h00001;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bcnt_q <= 20'h00000;
			fcnt_q <= 20'h00000;
		end else begin
			bcnt_q <= bcnt_d;
			fcnt_q <= fcnt_d;
		end
	end
	assign burst_enter = burst_win && fbl_s;

	// extension counter
	ext_state_t est_q, est_d;
	logic [15:0] ecnt_q, ecnt_d;
	always_comb begin
		est_d = est_q;
		ecnt_d = ecnt_q;
		case (est_q)
			EXT_IDLE: begin
				ecnt_d = 16'h0000;
				if (fault_win && ext_enable)
					est_d = EXT_CHARGE;
			end
			EXT_CHARGE: begin
				if (up_s) begin
					ecnt_d = ecnt_q + 16'h0001;
					est_d = (ecnt_q + 16'h0001 == `EXT_COUNT_END) ? EXT_DONE : EXT_DISCHARGE;
				end
			end
			EXT_DISCHARGE: begin
				if (lo_s)
					est_d = EXT_CHARGE;
			end
			EXT_DONE: ;
			default: est_d = EXT_IDLE;
		endcase
		if (!ovl_s)
			est_d = EXT_IDLE;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			est_q <= EXT_IDLE;
			ecnt_q <= 16'h0000;
		end else begin
			est_q <= est_d;
			ecnt_q <= ecnt_d;
		end
	end
	assign charge_switch = (est_q == EXT_CHARGE);
	assign discharge_switch = (est_q == EXT_DISCHARGE);
	assign ext_done = (est_q == EXT_DONE);

	// fault gate and 30us spike filter
	logic fault_and_gate;
	logic [10:0] spk_q, spk_d;
	logic ar_q, ar_d;
	assign fault_and_gate = fault_win && (ext_enable ? ext_done : 1'b1);
	always_comb begin
		spk_d = 11'h000;
		if (fault_and_gate)
			spk_d = (spk_q == 11'(`SPIKE_CYC)) ? spk_q : spk_q + 11'h001;
		ar_d = fault_and_gate && (spk_q == 11'(`SPIKE_CYC));
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			spk_q <= 11'h000;
			ar_q <= 1'b0;
		end else begin
			spk_q <= spk_d;
			ar_q <= ar_d;
		end
	end
	assign auto_restart = ar_q;

	// burst level detection
	det_state_t dst_q, dst_d;
	logic [15:0] win_q, win_d, dcnt_q, dcnt_d;
	logic lv_q, lv_d;
	burst_level_t lvl_q, lvl_d;
	function automatic burst_level_t map_level(input logic [15:0] n);
		if (n < `LVL_BOUND_HIGH)
			map_level = LVL_HIGH;
		else if (n < `LVL_BOUND_MID)
			map_level = LVL_MID;
		else if (n < `LVL_BOUND_LOW)
			map_level = LVL_LOW;
		else
			map_level = LVL_NEVER;
	endfunction : map_level
	always_comb begin
		dst_d = dst_q;
		win_d = win_q;
		dcnt_d = dcnt_q;
		lv_d = lv_q;
		lvl_d = lvl_q;
		case (dst_q)
			DET_WAIT: begin
				win_d = 16'h0000;
				dcnt_d = 16'h0000;
				if (lock_s && !rst_s && !prot_s && !lv_q)
					dst_d = DET_CHARGE;
			end
			DET_CHARGE, DET_DISCHARGE: begin
				win_d = win_q + 16'h0001;
				if (dst_q == DET_CHARGE && fbu_s) begin
					dst_d = DET_DISCHARGE;
					dcnt_d = dcnt_q + 16'h0001;
				end else if (dst_q == DET_DISCHARGE && fbd_s)
					dst_d = DET_CHARGE;
				if (win_q == 16'(`DETECT_CYC - 1))
					dst_d = DET_DONE;
			end
			DET_DONE: begin
				lvl_d = map_level(dcnt_q);
				lv_d = 1'b1;
				dst_d = DET_WAIT;
			end
			default: dst_d = DET_WAIT;
		endcase
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dst_q <= DET_WAIT;
			win_q <= 16'h0000;
			dcnt_q <= 16'h0000;
			lv_q <= 1'b0;
			lvl_q <= LVL_NEVER;
		end else begin
			dst_q <= dst_d;
			win_q <= win_d;
			dcnt_q <= dcnt_d;
			lv_q <= lv_d;
			lvl_q <= lvl_d;
		end
	end
	assign detect_flipflop = (dst_q == DET_DISCHARGE);
	assign feedback_discharge_switch = (dst_q == DET_DISCHARGE);
	assign level_valid = lv_q;
	assign burst_level = lvl_q;
	assign burst_limit_always = lv_q && (lvl_q == LVL_NEVER);
endmodule : blank_burst_ctrl
`default_nettype wire

/* tb/cap_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cap_pin_model #(
	parameter int FULL = 4
) (
	input wire logic ref_clk, // clock
	input wire logic chg, // charge path closed
	input wire logic dis, // discharge path closed
	output logic at_upper, // pin at upper threshold
	output logic at_lower // pin at lower threshold
);
	int v = 0;
	// pin voltage as a ramp, one step a cycle
	always @(posedge ref_clk) begin
		if (dis && v > 0)
			v <= v - 1;
		else if (chg && v < FULL)
			v <= v + 1;
	end
	assign at_upper = (v >= FULL);
	assign at_lower = (v == 0);
endmodule : cap_pin_model
`default_nettype wire

/* tb/blank_burst_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module blank_burst_properties
	import blank_burst_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic arst_n, // reset
	input wire logic gate_on, // turn-on
	input wire logic burst_active, // burst
	input wire logic turn_on_spike_mask, // mask
	input wire logic charge_switch, // charge
	input wire logic discharge_switch, // discharge
	input wire logic ext_done, // done
	input wire logic burst_enter, // entry
	input wire logic detect_flipflop, // detect
	input wire logic feedback_discharge_switch, // fb discharge
	input wire logic level_valid, // latched
	input wire burst_level_t burst_level, // level
	input wire logic burst_limit_always // limit
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	chk_mask_normal: assert property (gate_on && !burst_active |=>
		turn_on_spike_mask[*8] ##1 turn_on_spike_mask) else $error("normal mask short");
	chk_mask_burst: assert property (gate_on && burst_active |=>
		turn_on_spike_mask[*8]) else $error("burst mask short");
	chk_mask_end: assert property (gate_on && burst_active ##1 !gate_on[*8] |=>
		!turn_on_spike_mask) else $error("burst mask long");
	chk_switch_excl: assert property (!(charge_switch && discharge_switch))
		else $error("both switches closed");
	chk_done_idle: assert property (ext_done |-> !charge_switch && !discharge_switch)
		else $error("switch closed after done");
	chk_fb_pair: assert property (detect_flipflop == feedback_discharge_switch)
		else $error("detect and discharge differ");
	chk_level_hold: assert property (level_valid |=> level_valid && $stable(burst_level))
		else $error("level changed");
	chk_det_stops: assert property (level_valid |-> !detect_flipflop)
		else $error("detect after end");
	chk_limit_never: assert property (level_valid |->
		burst_limit_always == (burst_level == LVL_NEVER)) else $error("limit pairing");
	chk_burst_valid: assert property (burst_enter |-> level_valid &&
		burst_level != LVL_NEVER) else $error("burst without level");
	cover property (gate_on && burst_active);
	cover property ($rose(detect_flipflop));
	cover property ($rose(level_valid));
endmodule : blank_burst_properties
bind blank_burst_ctrl blank_burst_properties u_props (.*);
`default_nettype wire

/* tb/blank_burst_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module blank_burst_ctrl_tb;
	import blank_burst_pkg::*;
	logic ref_clk = 0, arst_n = 0, gate_on = 0, burst_active = 0, lock_ok = 0;
	logic restart_cycle = 0, protect_active = 1, fb_below = 0, fb_ovl = 0, ext_en = 0;
	logic up_c, lo_c, fb_up, fb_lo, mask, chg, dis, fds, det, det_q = 0, lv, lim;
	logic ar, be, ed, hi = 0;
	burst_level_t lvl;
	int seed = 72, num_errors = 0, cmp_count = 0, cyc = 0, det_cnt = 0, n, keep;
	blank_burst_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n), .gate_on(gate_on),
		.burst_active(burst_active), .supply_lockout_ok(lock_ok), .restart_cycle(restart_cycle),
		.protect_active(protect_active), .fb_below_entry(fb_below), .fb_overload(fb_ovl),
		.ext_enable(ext_en), .upper_threshold_comparator(up_c), .lower_threshold_comparator(lo_c),
		.fb_upper_cmp(fb_up), .fb_lower_cmp(fb_lo), .turn_on_spike_mask(mask),
		.charge_switch(chg), .discharge_switch(dis), .ext_done(ed), .auto_restart(ar),
		.burst_enter(be), .detect_flipflop(det), .feedback_discharge_switch(fds),
		.level_valid(lv), .burst_level(lvl), .burst_limit_always(lim));
	cap_pin_model #(.FULL(4)) ext_pin (.ref_clk(ref_clk), .chg(chg), .dis(dis),
		.at_upper(up_c), .at_lower(lo_c));
	cap_pin_model #(.FULL(950)) fb_pin (.ref_clk(ref_clk), .chg(!fds), .dis(fds),
		.at_upper(fb_up), .at_lower(fb_lo));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	function automatic burst_level_t lvl_of(input int c);
		if (c < 8) return LVL_HIGH;
		if (c < 32) return LVL_MID;
		if (c < 128) return LVL_LOW;
		return LVL_NEVER;
	endfunction : lvl_of
	// random fault and feedback levels, detection cycles counted at the port
	always @(posedge ref_clk) begin
		{fb_below, fb_ovl, ext_en} <= 3'($random(seed));
		det_q <= det;
		// flapping fault and feedback inputs never persist for 20ms
		if (ar !== 1'b0 || be !== 1'b0 || ed !== 1'b0 || chg !== 1'b0 || dis !== 1'b0)
			hi <= 1'b1;
		if (det && !det_q)
			det_cnt <= det_cnt + 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1;
		lock_ok <= 1;
		repeat (300) @(posedge ref_clk);
		check(8'(det_cnt), 8'h00);
		check(8'(lv), 8'h00);
		for (int i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			gate_on <= 1;
			burst_active <= (i < 2) ? i[0] : 1'($random(seed));
			@(posedge ref_clk);
			gate_on <= 0;
			n = 0;
			repeat (12) begin
				@(negedge ref_clk);
				if (mask === 1'b1)
					n++;
			end
			check(8'(n), burst_active ? 8'h08 : 8'h09);
		end
		protect_active <= 0;
		while (lv !== 1'b1)
			@(posedge ref_clk);
		check(8'(lvl), 8'(lvl_of(det_cnt)));
		check(8'(lvl), 8'(LVL_MID));
		check(8'(lim), 8'h00);
		keep = det_cnt;
		restart_cycle <= 1;
		lock_ok <= 0;
		repeat (50) @(posedge ref_clk);
		lock_ok <= 1;
		repeat (3000) @(posedge ref_clk);
		check(8'(det_cnt), 8'(keep));
		check(8'(lvl), 8'(LVL_MID));
		check(8'(hi), 8'h00);
		give_verdict();
	end
endmodule : blank_burst_ctrl_tb
`default_nettype wire
